// >>> rtl/pgwr_pkg.sv
// Purpose: shared constants and carriers for the planar graphics write/read path
// Assumes: 8-bit indexed register port, four byte-wide planes
// Notes:   offsets are register indices on the data port
package pgwr_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [3:0] IDX_FILL_VALUE   = 4'h0;
  localparam logic [3:0] IDX_FILL_ENABLE  = 4'h1;
  localparam logic [3:0] IDX_CMP_COLOUR   = 4'h2;
  localparam logic [3:0] IDX_ROT_FUNC     = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE   = 4'h4;
  localparam logic [3:0] IDX_MODE_CTRL    = 4'h5;
  localparam logic [3:0] IDX_MISC_CTRL    = 4'h6;
  localparam logic [3:0] IDX_CMP_IGNORE   = 4'h7;
  localparam logic [3:0] IDX_PIXEL_MASK   = 4'h8;
  localparam logic [3:0] IDX_LAST         = 4'h8;
  localparam logic [7:0] CRT_IDX_LATCH_RB = 8'h22;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int ROT_LSB      = 0;
  localparam int FUNC_LSB     = 3;
  localparam int WMODE_LSB    = 0;
  localparam int RMODE_BIT    = 3;
  localparam int ODDEVEN_BIT  = 4;
  localparam logic [7:0] RST_REG      = 8'h00;
  localparam logic [7:0] RST_MASK     = 8'hFF;
  localparam logic [3:0] RST_INDEX    = 4'h0;

  // ****************************************
  // enumerations and carriers
  // ****************************************
  typedef enum logic [1:0] {PGWR_FN_PASS, PGWR_FN_AND, PGWR_FN_OR, PGWR_FN_XOR} pgwr_func_t;
  typedef enum logic [1:0] {PGWR_WM0, PGWR_WM1, PGWR_WM2, PGWR_WM3} pgwr_wmode_t;

  typedef struct packed {
    logic [3:0][7:0] plane;
  } pgwr_planes_t;

  typedef struct packed {
    logic [3:0] fill_value;
    logic [3:0] fill_enable;
    logic [2:0] rotate;
    pgwr_func_t func;
    pgwr_wmode_t wmode;
    logic [7:0] pixel_mask;
  } pgwr_wcfg_t;

endpackage : pgwr_pkg

// >>> rtl/pgwr_byte_lane.sv
// Purpose: one byte lane of the write path (rotate, expand, function, mask)
// Assumes: latches hold the planes of the last memory read
// Notes:   pure combinational; instantiated once per data byte
`timescale 1ns/10ps
module pgwr_byte_lane
  import pgwr_pkg::*;
(
  // configuration and operands
  input  wire pgwr_wcfg_t   cfg_i,
  input  wire logic [7:0]   data_i,
  input  wire pgwr_planes_t latch_i,
  // result
  output pgwr_planes_t      wdata_o
);

  logic [15:0] dbl;
  logic [7:0]  rot;
  logic [7:0]  m3mask;

  // ****************************************
  // rotate right, then form the mode-3 mask
  // ****************************************
  assign dbl    = {data_i, data_i} >> cfg_i.rotate;
  assign rot    = dbl[7:0];
  assign m3mask = rot & cfg_i.pixel_mask;

  // per plane: source select, logical function, bit mask
  always_comb begin
    logic [7:0] src;
    logic [7:0] fn;
    logic [7:0] msk;
    src     = '0;
    fn      = '0;
    msk     = '0;
    wdata_o = '0;
    for (int p = 0; p < 4; p++) begin
      src = '0;
      fn  = '0;
      msk = cfg_i.pixel_mask;
      unique case (cfg_i.wmode)
        PGWR_WM0: begin
          src = cfg_i.fill_enable[p] ? {8{cfg_i.fill_value[p]}} : rot;
        end
        PGWR_WM1: begin
          src = latch_i.plane[p];
        end
        PGWR_WM2: begin
          src = {8{data_i[p]}};
        end
        PGWR_WM3: begin
          src = {8{cfg_i.fill_value[p]}};
          msk = m3mask;
        end
      endcase
      // function applies except in latch-copy mode
      if (cfg_i.wmode == PGWR_WM1) begin
        fn = src;
      end else begin
        unique case (cfg_i.func)
          PGWR_FN_PASS: fn = src;
          PGWR_FN_AND:  fn = src & latch_i.plane[p];
          PGWR_FN_OR:   fn = src | latch_i.plane[p];
          PGWR_FN_XOR:  fn = src ^ latch_i.plane[p];
        endcase
      end
      // mask 0 keeps the latched bit
      wdata_o.plane[p] = (fn & msk) | (latch_i.plane[p] & ~msk);
    end
  end

endmodule : pgwr_byte_lane

// >>> rtl/pgwr_path.sv
// Purpose: planar graphics write/read data path with indexed register bank
// Assumes: host strobes are single-cycle pulses from logic on clk_i
// Notes:   memory results arrive on mem_rd_valid_i; writes leave registered
//
// Contract
// - 4-bit index selects data registers 0-8
// - mode 0 enabled planes take fill bit
// - enable bit picks host data or fill
// - fill enable matters only in mode 0
// - read mode 1 returns per-pixel colour match
// - write data rotated right by count
// - rotate first, then logical function
// - function: pass, AND, OR, XOR with latches
// - read mode 0 returns map-selected plane
// - odd/even ignores select bit0, quad both
// - 16-bit writes processed per byte
// - mode 1 writes latches to all planes
// - every memory read loads the latches
// - mode 2 data bits form colour
// - mode 2 mask zero keeps latched pixel
// - mode 2 ignores fill, keeps function
// - mode 3 rotated data AND mask chooses
// - mode 3 ignores fill enable
// - CRT index 22h reads selected latch
// - writes to latch readback are ignored
// - ignore mask excludes planes from compare
// - bit mask zero keeps latched bit
// - read mode bit picks read path
`timescale 1ns/10ps
module pgwr_path
  import pgwr_pkg::*;
#(
  parameter int LANES = 2
)(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  // graphics register port
  input  wire logic                 idx_wr_i,
  input  wire logic                 dat_wr_i,
  input  wire logic                 dat_rd_i,
  input  wire logic [7:0]           reg_wdata_i,
  output logic [7:0]                reg_rdata_o,
  // CRT controller index port (readback only)
  input  wire logic                 crt_rd_i,
  input  wire logic                 crt_wr_i,
  input  wire logic [7:0]           crt_index_i,
  output logic [7:0]                crt_rdata_o,
  // quad (chained) mode indication
  input  wire logic                 quad_mode_i,
  // host memory write request
  input  wire logic                 cpu_wr_i,
  input  wire logic [LANES-1:0]     cpu_be_i,
  input  wire logic [LANES*8-1:0]   cpu_wdata_i,
  // planar memory write
  output logic                      mem_wr_o,
  output logic [LANES-1:0]          mem_be_o,
  output pgwr_planes_t [LANES-1:0]  mem_wdata_o,
  // planar memory read return
  input  wire logic                 mem_rd_valid_i,
  input  wire pgwr_planes_t [LANES-1:0] mem_rdata_i,
  // host memory read answer
  output logic                      cpu_rd_valid_o,
  output logic [LANES*8-1:0]        cpu_rdata_o
);

  // ****************************************
  // register bank
  // ****************************************
  logic [3:0]               graphics_register_pointer;
  logic [7:0]               regs [0:8];
  pgwr_planes_t [LANES-1:0] latch;
  pgwr_wcfg_t               wcfg;
  pgwr_planes_t [LANES-1:0] next_wdata;
  logic [LANES*8-1:0]       next_rdata;

  // decodes a map select under odd/even and quad restrictions
  function automatic logic [1:0] plane_sel(input logic [7:0] sel, input logic oddeven, input logic quad);
    logic [1:0] s;
    s = sel[1:0];
    if (quad) begin
      s = 2'h0;
    end else if (oddeven) begin
      s[0] = 1'b0;
    end
    return s;
  endfunction : plane_sel

  // index register keeps four bits
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      graphics_register_pointer <= RST_INDEX;
    end else if (idx_wr_i) begin
      graphics_register_pointer <= reg_wdata_i[3:0];
    end
  end

  // data registers, writes above index 8 dropped
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 9; i++) begin
        regs[i] <= (i == int'(IDX_PIXEL_MASK)) ? RST_MASK : RST_REG;
      end
    end else if (dat_wr_i && graphics_register_pointer <= IDX_LAST) begin
      regs[graphics_register_pointer] <= reg_wdata_i;
    end
  end

  // register read answer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (dat_rd_i) begin
      if (graphics_register_pointer <= IDX_LAST) begin
        reg_rdata_o <= regs[graphics_register_pointer];
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end else if (idx_wr_i) begin
      reg_rdata_o <= reg_rdata_o;
    end
  end

  // ****************************************
  // latches and readback
  // ****************************************
  // every memory read refreshes all four latches
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latch <= '0;
    end else if (mem_rd_valid_i) begin
      latch <= mem_rdata_i;
    end
  end

  // CRT readback of selected low-byte latch; CRT writes have no effect
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      crt_rdata_o <= 8'h00;
    end else if (crt_rd_i) begin
      if (crt_index_i == CRT_IDX_LATCH_RB) begin
        crt_rdata_o <= latch[0].plane[regs[IDX_READ_PLANE][1:0]];
      end else begin
        crt_rdata_o <= 8'h00;
      end
    end
  end
  // crt_wr_i is deliberately not decoded: no state depends on it

  // ****************************************
  // write path
  // ****************************************
  assign wcfg.fill_value  = regs[IDX_FILL_VALUE][3:0];
  assign wcfg.fill_enable = regs[IDX_FILL_ENABLE][3:0];
  assign wcfg.rotate      = regs[IDX_ROT_FUNC][ROT_LSB +: 3];
  assign wcfg.func        = pgwr_func_t'(regs[IDX_ROT_FUNC][FUNC_LSB +: 2]);
  assign wcfg.wmode       = pgwr_wmode_t'(regs[IDX_MODE_CTRL][WMODE_LSB +: 2]);
  assign wcfg.pixel_mask  = regs[IDX_PIXEL_MASK];

  // one lane per data byte
  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      pgwr_byte_lane u_lane (
        .cfg_i   (wcfg),
        .data_i  (cpu_wdata_i[g*8 +: 8]),
        .latch_i (latch[g]),
        .wdata_o (next_wdata[g])
      );
    end
  endgenerate

  // registered memory write
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_wr_o    <= 1'b0;
      mem_be_o    <= '0;
      mem_wdata_o <= '0;
    end else begin
      mem_wr_o <= cpu_wr_i;
      if (cpu_wr_i) begin
        mem_be_o    <= cpu_be_i;
        mem_wdata_o <= next_wdata;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    logic [1:0] s;
    logic [3:0] cc;
    logic [3:0] keep;
    logic [3:0] px;
    next_rdata = '0;
    s    = plane_sel(regs[IDX_READ_PLANE], regs[IDX_MODE_CTRL][ODDEVEN_BIT], quad_mode_i);
    cc   = regs[IDX_CMP_COLOUR][3:0];
    keep = regs[IDX_CMP_IGNORE][3:0];
    px   = '0;
    for (int l = 0; l < LANES; l++) begin
      if (regs[IDX_MODE_CTRL][RMODE_BIT]) begin
        for (int b = 0; b < 8; b++) begin
          for (int p = 0; p < 4; p++) begin
            px[p] = mem_rdata_i[l].plane[p][b];
          end
          next_rdata[l*8+b] = ((px ^ cc) & keep) == 4'h0;
        end
      end else begin
        next_rdata[l*8 +: 8] = mem_rdata_i[l].plane[s];
      end
    end
  end

  // host read answer registered
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_rd_valid_o <= 1'b0;
      cpu_rdata_o    <= '0;
    end else begin
      cpu_rd_valid_o <= mem_rd_valid_i;
      if (mem_rd_valid_i) begin
        cpu_rdata_o <= next_rdata;
      end
    end
  end

endmodule : pgwr_path

// >>> testbench/pgwr_path_chk.sv
// Purpose: port-level assertions for the planar write/read path
// Assumes: one clock, active-low asynchronous reset
// Notes:   bound to every pgwr_path by the bind at the foot
`timescale 1ns/10ps
module pgwr_path_chk
  import pgwr_pkg::*;
#(
  parameter int LANES = 2
)(
  // clock and reset
  input wire logic                     clk_i,
  input wire logic                     rstn_i,
  // watched ports
  input wire logic                     idx_wr_i,
  input wire logic                     dat_rd_i,
  input wire logic [7:0]               reg_wdata_i,
  input wire logic [7:0]               reg_rdata_o,
  input wire logic                     crt_rd_i,
  input wire logic [7:0]               crt_index_i,
  input wire logic [7:0]               crt_rdata_o,
  input wire logic                     cpu_wr_i,
  input wire logic [LANES-1:0]         cpu_be_i,
  input wire logic                     mem_wr_o,
  input wire logic [LANES-1:0]         mem_be_o,
  input wire pgwr_planes_t [LANES-1:0] mem_wdata_o,
  input wire logic                     mem_rd_valid_i,
  input wire logic                     cpu_rd_valid_o,
  input wire logic [LANES*8-1:0]       cpu_rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // write requests leave as single memory writes, data held between
  wr_follow_a: assert property (cpu_wr_i |=> mem_wr_o && mem_be_o == $past(cpu_be_i))
    else $error("memory write missing or wrong byte enables");
  wr_quiet_a: assert property (!cpu_wr_i |=> !mem_wr_o && $stable(mem_wdata_o))
    else $error("memory write without request");
  // memory returns reach the host one cycle later
  rd_follow_a: assert property (mem_rd_valid_i |=> cpu_rd_valid_o)
    else $error("host read answer missing");
  rd_quiet_a: assert property (!mem_rd_valid_i |=> !cpu_rd_valid_o && $stable(cpu_rdata_o))
    else $error("host read answer without memory return");
  // crt readback decodes only its own index and ignores writes
  crt_other_a: assert property (crt_rd_i && crt_index_i != CRT_IDX_LATCH_RB |=> crt_rdata_o == 8'h00)
    else $error("crt read of other index not zero");
  crt_hold_a: assert property (!crt_rd_i |=> $stable(crt_rdata_o))
    else $error("crt readback changed without read");
  // register answers hold; pointers above the bank read zero
  reg_hold_a: assert property (!dat_rd_i |=> $stable(reg_rdata_o))
    else $error("register answer changed without read");
  high_idx_a: assert property (idx_wr_i && reg_wdata_i[3:0] > 4'h8 ##1 dat_rd_i && !idx_wr_i |=> reg_rdata_o == 8'h00)
    else $error("read above the bank not zero");
endmodule : pgwr_path_chk

bind pgwr_path pgwr_path_chk #(.LANES(LANES)) i_chk (.clk_i(clk_i), .rstn_i(rstn_i), .idx_wr_i(idx_wr_i),
  .dat_rd_i(dat_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .crt_rd_i(crt_rd_i),
  .crt_index_i(crt_index_i), .crt_rdata_o(crt_rdata_o), .cpu_wr_i(cpu_wr_i), .cpu_be_i(cpu_be_i),
  .mem_wr_o(mem_wr_o), .mem_be_o(mem_be_o), .mem_wdata_o(mem_wdata_o), .mem_rd_valid_i(mem_rd_valid_i),
  .cpu_rd_valid_o(cpu_rd_valid_o), .cpu_rdata_o(cpu_rdata_o));

// >>> testbench/pgwr_mem_model.sv
// Purpose: planar memory word behind the write/read path
// Assumes: one addressed word of two byte lanes
// Notes:   an idle read bus shows the inverse of its last value
`timescale 1ns/10ps
module pgwr_mem_model
  import pgwr_pkg::*;
(
  // clock and bench control
  input  wire logic               clk_i,
  input  wire logic               rd_req_i,
  input  wire logic [1:0]         dly_i,
  input  wire logic               load_i,
  input  wire pgwr_planes_t [1:0] load_data_i,
  // design side
  input  wire logic               mem_wr_i,
  input  wire logic [1:0]         mem_be_i,
  input  wire pgwr_planes_t [1:0] mem_wdata_i,
  output logic                    mem_rd_valid_o = 1'b0,
  output pgwr_planes_t [1:0]      mem_rdata_o = '0
);
  pgwr_planes_t [1:0] store;
  int                 wait_n = -1;
  // store enabled lanes, answer a read dly_i+1 cycles after the request is sampled
  always @(posedge clk_i) begin
    mem_rd_valid_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (load_i)
      store <= load_data_i;
    for (int l = 0; l < 2; l++)
      if (mem_wr_i && mem_be_i[l]) store[l] <= mem_wdata_i[l];
    if (rd_req_i)
      wait_n <= int'(dly_i);
    else if (wait_n == 0) begin
      mem_rd_valid_o <= 1'b1;
      mem_rdata_o <= store;
      wait_n <= -1;
    end else if (wait_n > 0)
      wait_n <= wait_n - 1;
  end
endmodule : pgwr_mem_model

// >>> testbench/planar_graphics_write_read_path_bench.sv
// Purpose: random self-checking bench for the planar write/read path
// Assumes: two byte lanes, one memory word
// Notes:   bench model keeps its own registers, image and latches
`timescale 1ns/10ps
module planar_graphics_write_read_path_bench
  import pgwr_pkg::*;
;
  logic clk_i = 1'b0, rstn_i = 1'b0, idx_wr_i = 1'b0, dat_wr_i = 1'b0, dat_rd_i = 1'b0;
  logic crt_rd_i = 1'b0, crt_wr_i = 1'b0, quad_mode_i = 1'b0, cpu_wr_i = 1'b0;
  logic rd_req = 1'b0, load = 1'b0, mem_wr_o, mem_rd_valid_i, cpu_rd_valid_o;
  logic [7:0] reg_wdata_i = 8'h00, crt_index_i = 8'h00, reg_rdata_o, crt_rdata_o;
  logic [1:0] cpu_be_i = 2'h0, dly = 2'h0, mem_be_o;
  logic [15:0] cpu_wdata_i = 16'h0000, cpu_rdata_o;
  pgwr_planes_t [1:0] mem_wdata_o, mem_rdata_i, load_data = '0, img, lat;
  logic [7:0] regs [0:15];
  int n_mismatch = 0, samples_checked = 0, cyc = 0;

  pgwr_path #(.LANES(2)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .idx_wr_i(idx_wr_i), .dat_wr_i(dat_wr_i),
    .dat_rd_i(dat_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .crt_rd_i(crt_rd_i),
    .crt_wr_i(crt_wr_i), .crt_index_i(crt_index_i), .crt_rdata_o(crt_rdata_o), .quad_mode_i(quad_mode_i),
    .cpu_wr_i(cpu_wr_i), .cpu_be_i(cpu_be_i), .cpu_wdata_i(cpu_wdata_i), .mem_wr_o(mem_wr_o),
    .mem_be_o(mem_be_o), .mem_wdata_o(mem_wdata_o), .mem_rd_valid_i(mem_rd_valid_i),
    .mem_rdata_i(mem_rdata_i), .cpu_rd_valid_o(cpu_rd_valid_o), .cpu_rdata_o(cpu_rdata_o));
  pgwr_mem_model i_mem (.clk_i(clk_i), .rd_req_i(rd_req), .dly_i(dly), .load_i(load), .load_data_i(load_data),
    .mem_wr_i(mem_wr_o), .mem_be_i(mem_be_o), .mem_wdata_i(mem_wdata_o), .mem_rd_valid_o(mem_rd_valid_i),
    .mem_rdata_o(mem_rdata_i));

  // clock and hang guard
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // host read result: colour compare or selected plane
  function automatic logic [7:0] rd_exp(input pgwr_planes_t p);
    logic [7:0] r;
    for (int b = 0; b < 8; b++)
      r[b] = ((({p.plane[3][b], p.plane[2][b], p.plane[1][b], p.plane[0][b]} ^ regs[2][3:0]) & regs[7][3:0]) == 4'h0);
    return regs[5][3] ? r : p.plane[quad_mode_i ? 2'h0 : {regs[4][1], regs[4][0] & ~regs[5][4]}];
  endfunction : rd_exp

  // one written byte lane: source by mode, function, then bit mask
  function automatic logic [31:0] wr_exp(input logic [7:0] d, input pgwr_planes_t l);
    logic [7:0] rot, m, v;
    logic [31:0] r;
    rot = 8'({d, d} >> regs[3][2:0]);
    m = (regs[5][1:0] == 2'h3) ? (rot & regs[8]) : regs[8];
    for (int p = 0; p < 4; p++) begin
      v = (regs[5][1:0] == 2'h2) ? {8{d[p]}} : {8{regs[0][p]}};
      if (regs[5][1:0] == 2'h0 && !regs[1][p])
        v = rot;
      case (regs[3][4:3])
        2'h1: v = v & l.plane[p];
        2'h2: v = v | l.plane[p];
        2'h3: v = v ^ l.plane[p];
        default: v = v;
      endcase
      if (regs[5][1:0] == 2'h1)
        v = l.plane[p];
      r[p*8 +: 8] = (v & m) | (l.plane[p] & ~m);
    end
    return r;
  endfunction : wr_exp

  task automatic reg_wr(input logic [3:0] i, input logic [7:0] v);
    @(posedge clk_i) idx_wr_i <= 1'b1;
    reg_wdata_i <= {4'h0, i};
    @(posedge clk_i) idx_wr_i <= 1'b0;
    dat_wr_i <= 1'b1;
    reg_wdata_i <= v;
    @(posedge clk_i) dat_wr_i <= 1'b0;
    if (i <= 4'h8)
      regs[i] = v;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] i);
    @(posedge clk_i) idx_wr_i <= 1'b1;
    reg_wdata_i <= {4'h0, i};
    @(posedge clk_i) idx_wr_i <= 1'b0;
    dat_rd_i <= 1'b1;
    @(posedge clk_i) dat_rd_i <= 1'b0;
    #1 check("register", 32'(reg_rdata_o), 32'(regs[i]));
  endtask : reg_rd

  task automatic mem_rd;
    @(posedge clk_i) rd_req <= 1'b1;
    dly <= 2'($urandom);
    @(posedge clk_i) rd_req <= 1'b0;
    repeat (10) begin
      @(posedge clk_i) #1;
      if (cpu_rd_valid_o === 1'b1) break;
    end
    check("read valid", 32'(cpu_rd_valid_o), 32'h1);
    lat = img;
    for (int l = 0; l < 2; l++)
      check("read data", 32'(cpu_rdata_o[l*8 +: 8]), 32'(rd_exp(img[l])));
  endtask : mem_rd

  task automatic mem_wr;
    logic [15:0] d;
    logic [1:0]  be;
    d = 16'($urandom);
    be = 2'($urandom);
    @(posedge clk_i) cpu_wr_i <= 1'b1;
    cpu_be_i <= be;
    cpu_wdata_i <= d;
    @(posedge clk_i) cpu_wr_i <= 1'b0;
    #1 check("write be", 32'(mem_be_o), 32'(be));
    check("write strobe", 32'(mem_wr_o), 32'h1);
    for (int l = 0; l < 2; l++)
      if (be[l]) begin
        img[l] = wr_exp(d[l*8 +: 8], lat[l]);
        check("write data", mem_wdata_o[l], img[l]);
      end
  endtask : mem_wr

  // reset values, then random configurations, reads and writes
  initial begin
    void'($urandom(41));
    foreach (regs[i]) regs[i] = (i == 8) ? 8'hFF : 8'h00;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 10; i++) reg_rd(4'(i));
    for (int t = 0; t < 40; t++) begin
      for (int i = 0; i < 10; i++) reg_wr(4'(i), 8'($urandom));
      reg_wr(4'($urandom_range(15, 9)), 8'($urandom));
      reg_rd(4'($urandom_range(15)));
      @(posedge clk_i) load <= 1'b1;
      quad_mode_i <= 1'($urandom);
      load_data <= {$urandom, $urandom};
      @(posedge clk_i) load <= 1'b0;
      img = load_data;
      mem_rd();
      @(posedge clk_i) crt_rd_i <= 1'b1;
      crt_wr_i <= 1'($urandom);
      crt_index_i <= $urandom_range(1) ? CRT_IDX_LATCH_RB : 8'($urandom);
      @(posedge clk_i) crt_rd_i <= 1'b0;
      crt_wr_i <= 1'b0;
      #1 check("readback", 32'(crt_rdata_o),
               32'(crt_index_i == CRT_IDX_LATCH_RB ? lat[0].plane[regs[4][1:0]] : 8'h00));
      mem_wr();
      mem_wr();
      mem_rd();
    end
    give_verdict();
  end
endmodule : planar_graphics_write_read_path_bench
